// ### rtl/reclocker_config_control.sv
// Purpose: Configuration, mode and eye monitor control of a reclocker
// Assumes: Wishbone classic slave, pins sampled on clk_i
// Notes: Analog paths are steered by the registered outputs
// Functional notes
// - Pins classify into L, R, F, H levels
// - Power save without carrier, wake on carrier
// - Equalizer bypass by pin or register
// - Manual boost or adaptive pick of sixteen presets
// - Adaptive equalizer mode is the default
// - Adapt only fast rates, else fixed boost
// - Routing pin selects family and primary output
// - Override bits replace pin routing and rate
// - Recovery loop locks and resamples equalized data
// - Video rates reclocked, lowest rate bypassed
// - Sub-rates only for four upper video rates
// - Register override flips the rate family
// - Carrier loss resets the recovery loop
// - Eye monitor runs only at 2.97G and up
// - Eye matrix is 64 by 64 points
// - Bits per matrix point are configurable
// - Report horizontal eye width at zero volts
// - Report vertical eye height at mid phase
// - Output pin H raw, L equalized only
`timescale 1ns/1ps
module reclocker_config_control (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [8:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Configuration pin voltages
    input wire logic [7:0] route_pin_code_i,
    input wire logic [7:0] out_fn_pin_code_i,
    // Analog status
    input wire logic carrier_detect_i,
    input wire logic [2:0] rate_i,
    input wire logic [7:0] eq_metric_i,
    input wire logic eye_bit_strobe_i,
    input wire logic eye_hit_i,
    // Datapath control
    output logic [7:0] eq_boost_o,
    output logic eq_bypass_o,
    output logic cdr_bypass_o,
    output logic cdr_reset_o,
    output logic subrate_enable_o,
    output logic power_save_o,
    output logic rate_10g_o,
    output logic primary_output_enable_o,
    output logic secondary_output_enable_o,
    output logic secondary_clock_o,
    // Eye monitor steering
    output logic eye_monitor_busy_o,
    output logic [5:0] eye_phase_o,
    output logic [5:0] eye_voltage_o,
    output logic [5:0] eye_span_o
);
    typedef enum logic [1:0] {
        A_IDLE = 2'b00,
        A_SWEEP = 2'b01,
        A_HOLD = 2'b10
    } adapt_state_t;

    typedef struct packed {
        logic ack;
        logic [31:0] rdat;
        logic route_ovr;
        logic [1:0] route_val;
        logic fam_ovr;
        logic fam_val;
        logic byp_ovr;
        logic byp_val;
        logic manual;
        logic cdr_rst_sw;
        logic [7:0] manual_boost;
        logic [7:0] low_boost;
        logic [15:0] eom_bits;
        logic [5:0] eom_span;
        logic [11:0] hit_addr;
        logic [127:0] presets;
        adapt_state_t ast;
        logic [3:0] aidx;
        logic [3:0] best;
        logic [7:0] best_metric;
        logic [7:0] dwell;
        logic eom_busy;
        logic eom_done;
        logic [5:0] phase;
        logic [5:0] volt;
        logic [15:0] bitcnt;
        logic [15:0] hitcnt;
        logic [6:0] horizontal_eye_width;
        logic [6:0] vertical_eye_height;
        logic mwe;
        logic [11:0] maddr;
        logic [15:0] mwdata;
        logic [7:0] eq_boost;
        logic eq_bypass;
        logic cdr_bypass;
        logic cdr_reset;
        logic subrate_en;
        logic power_save;
        logic fam10g;
        logic pri_en;
        logic sec_en;
        logic sec_clock;
    } state_t;

    state_t s;
    state_t next_s;
    logic [1:0] io_lvl;
    logic [1:0] out_lvl;
    logic [15:0] mem_rdata;
    logic [31:0] rv;
    logic [31:0] wv;
    logic [31:0] wm;
    logic [3:0] pidx;
    logic [1:0] route_lvl;
    logic [1:0] route;
    logic fam;
    logic fast;
    logic start;
    logic [15:0] hits;

    // ==========================================
    // Helpers
    function automatic logic [1:0] route_decode(input logic [1:0] lvl);
        case (lvl)
            rc_pkg::LVL_H: route_decode = 2'b01;
            rc_pkg::LVL_F: route_decode = 2'b00;
            rc_pkg::LVL_R: route_decode = 2'b10;
            default: route_decode = 2'b11;
        endcase
    endfunction

    function automatic logic rate_fast(input logic [2:0] r);
        rate_fast = (r == rc_pkg::RATE_11G88) || (r == rc_pkg::RATE_5G94) ||
                    (r == rc_pkg::RATE_2G97) || (r == rc_pkg::RATE_10G3125);
    endfunction

    function automatic logic is_preset(input logic [8:0] a);
        is_preset = (a[8:6] == rc_pkg::PRESET_INDEX_BASE[6:4]) && (a[1:0] == 2'b00);
    endfunction

    // ==========================================
    // Pin level classifiers and hit store
    level_classifier route_pin (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_code_i(route_pin_code_i),
        .level_o(io_lvl)
    );

    level_classifier out_fn_pin (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_code_i(out_fn_pin_code_i),
        .level_o(out_lvl)
    );

    hit_memory #(
        .ADDR_W(12),
        .DATA_W(16)
    ) hits_store (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .we_i(s.mwe),
        .waddr_i(s.maddr),
        .wdata_i(s.mwdata),
        .raddr_i(s.hit_addr),
        .rdata_o(mem_rdata)
    );

    // ==========================================
    // Next state
    always_comb
    begin
        next_s = s;
        rv = 32'h0;
        wm = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
        pidx = wb_adr_i[5:2];
        start = 1'b0;
        hits = 16'h0;
        case (wb_adr_i)
            rc_pkg::ADDR_CTRL: rv = {22'h0, 1'b0, s.cdr_rst_sw, s.manual, s.byp_val, s.byp_ovr,
                                     s.fam_val, s.fam_ovr, s.route_val, s.route_ovr};
            rc_pkg::ADDR_BOOST: rv = {16'h0, s.low_boost, s.manual_boost};
            rc_pkg::ADDR_EOM_CFG: rv = {10'h0, s.eom_span, s.eom_bits};
            rc_pkg::ADDR_STATUS: rv = {14'h0, rate_i, s.eq_bypass, s.cdr_bypass, s.eom_done, s.eom_busy,
                                       s.ast == A_HOLD, s.best, s.fam10g, s.power_save, out_lvl, io_lvl};
            rc_pkg::ADDR_EYE: rv = {16'h0, 1'b0, s.vertical_eye_height, 1'b0, s.horizontal_eye_width};
            rc_pkg::ADDR_HIT_ADDR: rv = {20'h0, s.hit_addr};
            rc_pkg::ADDR_HIT_DATA: rv = {16'h0, mem_rdata};
            default:
            begin
                if (is_preset(wb_adr_i))
                    rv = {24'h0, s.presets[{pidx, 3'b000} +: 8]};
            end
        endcase
        wv = (rv & ~wm) | (wb_dat_i & wm);
        next_s.ack = wb_cyc_i & wb_stb_i & ~s.ack;
        next_s.rdat = rv;
        if (next_s.ack && wb_we_i)
        begin
            case (wb_adr_i)
                rc_pkg::ADDR_CTRL:
                begin
                    next_s.route_ovr = wv[rc_pkg::CTRL_ROUTE_OVR];
                    next_s.route_val = wv[rc_pkg::CTRL_ROUTE_LSB +: 2];
                    next_s.fam_ovr = wv[rc_pkg::CTRL_FAM_OVR];
                    next_s.fam_val = wv[rc_pkg::CTRL_FAM_VAL];
                    next_s.byp_ovr = wv[rc_pkg::CTRL_BYP_OVR];
                    next_s.byp_val = wv[rc_pkg::CTRL_BYP_VAL];
                    next_s.manual = wv[rc_pkg::CTRL_MANUAL];
                    next_s.cdr_rst_sw = wv[rc_pkg::CTRL_CDR_RST];
                    start = wv[rc_pkg::CTRL_EOM_START];
                end
                rc_pkg::ADDR_BOOST:
                begin
                    next_s.manual_boost = wv[7:0];
                    next_s.low_boost = wv[15:8];
                end
                rc_pkg::ADDR_EOM_CFG:
                begin
                    next_s.eom_bits = wv[15:0];
                    next_s.eom_span = wv[21:16];
                end
                rc_pkg::ADDR_HIT_ADDR: next_s.hit_addr = wv[11:0];
                default:
                begin
                    if (is_preset(wb_adr_i))
                        next_s.presets[{pidx, 3'b000} +: 8] = wv[7:0];
                end
            endcase
        end

        // Routing, family and path selection
        route_lvl = s.route_ovr ? s.route_val : io_lvl;
        route = route_decode(route_lvl);
        fam = s.fam_ovr ? s.fam_val : route[1];
        fast = rate_fast(rate_i);
        next_s.fam10g = fam;
        next_s.pri_en = route[0] & carrier_detect_i;
        next_s.sec_en = carrier_detect_i;
        next_s.power_save = ~carrier_detect_i;
        next_s.eq_bypass = s.byp_ovr ? s.byp_val : (out_lvl == rc_pkg::LVL_H);
        next_s.cdr_bypass = (out_lvl == rc_pkg::LVL_H) || (out_lvl == rc_pkg::LVL_L) ||
                            (rate_i == rc_pkg::RATE_LOW);
        next_s.sec_clock = (out_lvl == rc_pkg::LVL_R) & ~fam;
        next_s.subrate_en = (rate_i <= rc_pkg::RATE_1G485) & ~fam;
        next_s.cdr_reset = s.cdr_rst_sw | ~carrier_detect_i;

        // Adaptive equalizer sweep
        case (s.ast)
            A_IDLE:
            begin
                if (carrier_detect_i && !s.manual && fast)
                begin
                    next_s.ast = A_SWEEP;
                    next_s.aidx = 4'h0;
                    next_s.dwell = 8'h0;
                    next_s.best = 4'h0;
                    next_s.best_metric = 8'h0;
                end
            end
            A_SWEEP:
            begin
                if (s.dwell == rc_pkg::ADAPT_DWELL_CYC - 8'h1)
                begin
                    next_s.dwell = 8'h0;
                    if (s.aidx == 4'h0 || eq_metric_i > s.best_metric)
                    begin
                        next_s.best = s.aidx;
                        next_s.best_metric = eq_metric_i;
                    end
                    if (s.aidx == 4'hf)
                        next_s.ast = A_HOLD;
                    else
                        next_s.aidx = s.aidx + 4'h1;
                end
                else
                    next_s.dwell = s.dwell + 8'h1;
            end
            A_HOLD: next_s.ast = A_HOLD;
            default: next_s.ast = A_IDLE;
        endcase
        if (!carrier_detect_i || s.manual || !fast || fam != s.fam10g)
            next_s.ast = A_IDLE;
        if (s.manual)
            next_s.eq_boost = s.manual_boost;
        else if (!fast)
            next_s.eq_boost = s.low_boost;
        else if (s.ast == A_SWEEP)
            next_s.eq_boost = s.presets[{s.aidx, 3'b000} +: 8];
        else
            next_s.eq_boost = s.presets[{s.best, 3'b000} +: 8];

        // Eye monitor capture
        next_s.mwe = 1'b0;
        if (start && fast && carrier_detect_i)
        begin
            next_s.eom_busy = 1'b1;
            next_s.eom_done = 1'b0;
            next_s.phase = 6'h0;
            next_s.volt = 6'h0;
            next_s.bitcnt = 16'h0;
            next_s.hitcnt = 16'h0;
            next_s.horizontal_eye_width = 7'h0;
            next_s.vertical_eye_height = 7'h0;
        end
        else if (s.eom_busy)
        begin
            if (!fast)
                next_s.eom_busy = 1'b0;
            else if (eye_bit_strobe_i)
            begin
                hits = s.hitcnt + {15'h0, eye_hit_i};
                if ({1'b0, s.bitcnt} + 17'h1 >= {1'b0, s.eom_bits})
                begin
                    next_s.mwe = 1'b1;
                    next_s.maddr = {s.volt, s.phase};
                    next_s.mwdata = hits;
                    if (hits == 16'h0 && s.volt == rc_pkg::EOM_MID)
                        next_s.horizontal_eye_width = s.horizontal_eye_width + 7'h1;
                    if (hits == 16'h0 && s.phase == rc_pkg::EOM_MID)
                        next_s.vertical_eye_height = s.vertical_eye_height + 7'h1;
                    next_s.bitcnt = 16'h0;
                    next_s.hitcnt = 16'h0;
                    next_s.phase = s.phase + 6'h1;
                    if (s.phase == rc_pkg::EOM_LAST)
                    begin
                        next_s.volt = s.volt + 6'h1;
                        if (s.volt == rc_pkg::EOM_LAST)
                        begin
                            next_s.eom_busy = 1'b0;
                            next_s.eom_done = 1'b1;
                        end
                    end
                end
                else
                begin
                    next_s.bitcnt = s.bitcnt + 16'h1;
                    next_s.hitcnt = hits;
                end
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s <= '0;
            s.presets <= rc_pkg::PRESET_RST;
            s.low_boost <= rc_pkg::LOW_BOOST_RST;
            s.eom_bits <= rc_pkg::EOM_BITS_RST;
            s.eom_span <= rc_pkg::EOM_SPAN_RST;
            s.cdr_reset <= 1'b1;
            s.power_save <= 1'b1;
        end
        else
            s <= next_s;
    end

    // ==========================================
    // Outputs
    assign wb_dat_o = s.rdat;
    assign wb_ack_o = s.ack;
    assign eq_boost_o = s.eq_boost;
    assign eq_bypass_o = s.eq_bypass;
    assign cdr_bypass_o = s.cdr_bypass;
    assign cdr_reset_o = s.cdr_reset;
    assign subrate_enable_o = s.subrate_en;
    assign power_save_o = s.power_save;
    assign rate_10g_o = s.fam10g;
    assign primary_output_enable_o = s.pri_en;
    assign secondary_output_enable_o = s.sec_en;
    assign secondary_clock_o = s.sec_clock;
    assign eye_monitor_busy_o = s.eom_busy;
    assign eye_phase_o = s.phase;
    assign eye_voltage_o = s.volt;
    assign eye_span_o = s.eom_span;

    // ==========================================
    // Checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    chk_power_save_follow:
    assert property (carrier_detect_i != $past(carrier_detect_i) |=> power_save_o == !$past(carrier_detect_i))
        else $error("power save does not follow carrier");
    chk_route_pin_high:
    assert property (io_lvl == rc_pkg::LVL_H && !s.route_ovr && !s.fam_ovr && carrier_detect_i
                     |=> primary_output_enable_o && !rate_10g_o)
        else $error("route pin H not decoded");
    chk_route_override:
    assert property (s.route_ovr && s.route_val == rc_pkg::LVL_R && !s.fam_ovr
                     |=> !primary_output_enable_o && rate_10g_o)
        else $error("route override lost to pin");
    chk_low_rate_boost:
    assert property (!s.manual && rate_i == rc_pkg::RATE_1G485 ##1 !s.manual && $stable(s.low_boost)
                     |-> eq_boost_o == s.low_boost)
        else $error("fixed boost not applied");
    chk_lowest_rate_bypass:
    assert property (rate_i == rc_pkg::RATE_LOW |=> cdr_bypass_o)
        else $error("recovery not bypassed at lowest rate");
    chk_subrate_gate:
    assert property (rate_i == rc_pkg::RATE_270M |=> !subrate_enable_o)
        else $error("sub-rate enabled at lowest video rate");
    chk_eye_rate_gate:
    assert property (!rate_fast(rate_i) |=> !eye_monitor_busy_o)
        else $error("eye monitor running at slow rate");
    chk_carrier_cdr_reset:
    assert property ($fell(carrier_detect_i) |=> cdr_reset_o)
        else $error("recovery not reset on carrier loss");
    chk_raw_path:
    assert property (out_lvl == rc_pkg::LVL_H && !s.byp_ovr |=> eq_bypass_o && cdr_bypass_o)
        else $error("raw path not bypassed");
    chk_adapt_sweep_step:
    assert property (s.ast == A_SWEEP && s.dwell == rc_pkg::ADAPT_DWELL_CYC - 8'h1 && s.aidx != 4'hf
                     && next_s.ast == A_SWEEP |=> s.aidx == $past(s.aidx) + 4'h1)
        else $error("adaptive sweep skipped a preset");
endmodule

// ### rtl/rc_pkg.sv
// Purpose: Shared constants for the reclocker configuration control
// Assumes: 25 MHz system clock, Wishbone register access
// Notes: Pin voltages arrive as 8-bit fractions of the I/O supply
package rc_pkg;
    // ==========================================
    // Four-level pin codes, rising order
    localparam logic [1:0] LVL_L = 2'h0;
    localparam logic [1:0] LVL_R = 2'h1;
    localparam logic [1:0] LVL_F = 2'h2;
    localparam logic [1:0] LVL_H = 2'h3;
    // Boundaries at 0.2, 0.5 and 0.8 of io_supply, full scale 8'hff
    localparam logic [7:0] THR_LR = 8'h33;
    localparam logic [7:0] THR_RF = 8'h80;
    localparam logic [7:0] THR_FH = 8'hcc;

    // ==========================================
    // Detected rate codes
    localparam logic [2:0] RATE_11G88 = 3'h0;
    localparam logic [2:0] RATE_5G94 = 3'h1;
    localparam logic [2:0] RATE_2G97 = 3'h2;
    localparam logic [2:0] RATE_1G485 = 3'h3;
    localparam logic [2:0] RATE_270M = 3'h4;
    localparam logic [2:0] RATE_LOW = 3'h5;
    localparam logic [2:0] RATE_10G3125 = 3'h6;

    // ==========================================
    // Register byte addresses
    localparam int ADR_W = 9;
    localparam logic [8:0] ADDR_CTRL = 9'h000;
    localparam logic [8:0] ADDR_BOOST = 9'h004;
    localparam logic [8:0] ADDR_EOM_CFG = 9'h008;
    localparam logic [8:0] ADDR_STATUS = 9'h00c;
    localparam logic [8:0] ADDR_EYE = 9'h010;
    localparam logic [8:0] ADDR_HIT_ADDR = 9'h014;
    localparam logic [8:0] ADDR_HIT_DATA = 9'h018;
    // Preset registers: index 0x40-0x4f, byte address is four times index
    localparam logic [6:0] PRESET_INDEX_BASE = 7'h40;

    // ==========================================
    // Control register fields
    localparam int CTRL_ROUTE_OVR = 0;
    localparam int CTRL_ROUTE_LSB = 1;
    localparam int CTRL_FAM_OVR = 3;
    localparam int CTRL_FAM_VAL = 4;
    localparam int CTRL_BYP_OVR = 5;
    localparam int CTRL_BYP_VAL = 6;
    localparam int CTRL_MANUAL = 7;
    localparam int CTRL_CDR_RST = 8;
    localparam int CTRL_EOM_START = 9;

    // ==========================================
    // Reset values
    localparam logic [7:0] LOW_BOOST_RST = 8'h00;
    localparam logic [15:0] EOM_BITS_RST = 16'h0100;
    localparam logic [5:0] EOM_SPAN_RST = 6'h3f;
    localparam logic [127:0] PRESET_RST = 128'hf0e0d0c0b0a090807060504030201000;

    // ==========================================
    // Timing and eye monitor geometry
    localparam int CLK_PERIOD_NS = 40;
    localparam int ADAPT_DWELL_NS = 10000;
    localparam logic [7:0] ADAPT_DWELL_CYC = 8'((ADAPT_DWELL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [5:0] EOM_MID = 6'h20;
    localparam logic [5:0] EOM_LAST = 6'h3f;
endpackage

// ### rtl/level_classifier.sv
// Purpose: Turns a pin voltage code into one of four levels
// Assumes: Code is synchronous to clk_i
// Notes: Output registered, reset shows the float level
`timescale 1ns/1ps
module level_classifier (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Pin voltage and level
    input wire logic [7:0] pin_code_i,
    output logic [1:0] level_o
);
    typedef struct packed {
        logic [1:0] level;
    } lvl_state_t;

    lvl_state_t s;
    lvl_state_t next_s;

    // ==========================================
    // Threshold compare
    always_comb
    begin
        next_s = s;
        if (pin_code_i >= rc_pkg::THR_FH)
            next_s.level = rc_pkg::LVL_H;
        else if (pin_code_i >= rc_pkg::THR_RF)
            next_s.level = rc_pkg::LVL_F;
        else if (pin_code_i >= rc_pkg::THR_LR)
            next_s.level = rc_pkg::LVL_R;
        else
            next_s.level = rc_pkg::LVL_L;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            s <= '{level: rc_pkg::LVL_F};
        else
            s <= next_s;
    end

    assign level_o = s.level;
endmodule

// ### rtl/hit_memory.sv
// Purpose: Hit count store for the eye matrix
// Assumes: One write and one read port on one clock
// Notes: Read data registered, one cycle after address
`timescale 1ns/1ps
module hit_memory #(
    parameter int ADDR_W = 12,
    parameter int DATA_W = 16
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Write port
    input wire logic we_i,
    input wire logic [ADDR_W-1:0] waddr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    // Read port
    input wire logic [ADDR_W-1:0] raddr_i,
    output logic [DATA_W-1:0] rdata_o
);
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

    // ==========================================
    // Storage
    always_ff @(posedge clk_i)
    begin
        if (we_i)
            mem[waddr_i] <= wdata_i;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            rdata_o <= '0;
        else
            rdata_o <= mem[raddr_i];
    end
endmodule

// ### tb/serial_source.sv
// Purpose: Serial source model facing the reclocker
// Assumes: Bench sets carrier and rate
// Notes: Eye quality peaks at boost 8'h50
`timescale 1ns/1ps
module serial_source (
    // Clock
    input wire logic clk_i,
    // Bench control and device boost
    input wire logic carrier_on_i,
    input wire logic [2:0] rate_sel_i,
    input wire logic [7:0] boost_i,
    // Device side
    output logic carrier_detect_o,
    output logic [2:0] rate_o,
    output logic [7:0] metric_o,
    output logic strobe_o,
    output logic hit_o
);
    logic [1:0] cnt = 2'h0;
    always_ff @(posedge clk_i)
    begin
        cnt <= cnt + 2'h1;
    end
    assign carrier_detect_o = carrier_on_i;
    assign rate_o = rate_sel_i;
    assign metric_o = (boost_i > 8'h50) ? 8'hff - (boost_i - 8'h50) : 8'hff - (8'h50 - boost_i);
    assign strobe_o = carrier_on_i & cnt[0];
    assign hit_o = cnt[1];
endmodule

// ### tb/test_reclocker_config_control.sv
// Purpose: Self-checking bench for reclocker control
// Assumes: Wishbone classic, 25 MHz clock
// Notes: Adapt sweep takes about 4000 cycles
`timescale 1ns/1ps
module test_reclocker_config_control;
    logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, carrier_on = 1'b0;
    logic [8:0] wb_adr_i = 9'h000;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rdata, h0;
    logic [5:0] span;
    logic wb_ack_o, cd, strobe, hit, eq_bypass_o, cdr_bypass_o, cdr_reset_o, subrate_enable_o, power_save_o;
    logic rate_10g_o, primary_output_enable_o, secondary_output_enable_o, busy, sclk;
    logic [7:0] route_code = 8'hff, fn_code = 8'haa, metric, eq_boost_o;
    logic [2:0] rate_sel = 3'h0, rate;
    logic [7:0] codes [8] = '{8'h00, 8'h30, 8'h36, 8'h7d, 8'h83, 8'hc9, 8'hcf, 8'hff};
    logic [2:0] exp_route [8] = '{3'h7, 3'h7, 3'h5, 3'h5, 3'h1, 3'h1, 3'h3, 3'h3};
    int mismatches = 0, tests_run = 0;
    always #20 clk_i = ~clk_i;
    serial_source serial_source_inst (.clk_i(clk_i), .carrier_on_i(carrier_on), .rate_sel_i(rate_sel),
        .boost_i(eq_boost_o), .carrier_detect_o(cd), .rate_o(rate), .metric_o(metric), .strobe_o(strobe),
        .hit_o(hit));
    reclocker_config_control reclocker_config_control_inst (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .route_pin_code_i(route_code),
        .out_fn_pin_code_i(fn_code), .carrier_detect_i(cd), .rate_i(rate), .eq_metric_i(metric),
        .eye_bit_strobe_i(strobe), .eye_hit_i(hit), .eq_boost_o(eq_boost_o), .eq_bypass_o(eq_bypass_o),
        .cdr_bypass_o(cdr_bypass_o), .cdr_reset_o(cdr_reset_o), .subrate_enable_o(subrate_enable_o),
        .power_save_o(power_save_o), .rate_10g_o(rate_10g_o), .primary_output_enable_o(primary_output_enable_o),
        .secondary_output_enable_o(secondary_output_enable_o), .secondary_clock_o(sclk),
        .eye_monitor_busy_o(busy), .eye_phase_o(), .eye_voltage_o(), .eye_span_o(span));
    // ==========================================
    // Shared tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic we, input logic [8:0] adr, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= wd;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 50);
        if (wb_ack_o !== 1'b1)
            mismatches++;
        rdata = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic rd_chk(input logic [8:0] adr, input logic [31:0] exp);
        xfer(1'b0, adr, 32'h0);
        check(rdata, exp);
    endtask
    task automatic settle(input string name);
        repeat (4) @(posedge clk_i);
        $display("step %0s done", name);
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        give_verdict();
    end
    // ==========================================
    // Tests
    initial
    begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        settle("reset");
        check({power_save_o, cdr_reset_o}, 32'h3);
        rd_chk(rc_pkg::ADDR_BOOST, 32'h0);
        rd_chk(rc_pkg::ADDR_EOM_CFG, 32'h003f0100);
        rd_chk(9'h114, 32'h50);
        rd_chk(9'h1fc, 32'h0);
        carrier_on <= 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            route_code <= codes[i];
            settle("route");
            check({rate_10g_o, primary_output_enable_o, secondary_output_enable_o}, exp_route[i]);
        end
        xfer(1'b1, rc_pkg::ADDR_CTRL, 32'h3);
        settle("override");
        check({rate_10g_o, primary_output_enable_o, secondary_output_enable_o}, 32'h5);
        xfer(1'b1, rc_pkg::ADDR_CTRL, 32'h118);
        settle("family");
        check({rate_10g_o, cdr_reset_o}, 32'h3);
        xfer(1'b1, rc_pkg::ADDR_CTRL, 32'h0);
        settle("release");
        check({rate_10g_o, cdr_reset_o}, 32'h0);
        carrier_on <= 1'b0;
        settle("loss");
        check({power_save_o, cdr_reset_o, primary_output_enable_o}, 32'h6);
        carrier_on <= 1'b1;
        settle("wake");
        check({power_save_o, cdr_reset_o, primary_output_enable_o}, 32'h1);
        fn_code <= 8'hff;
        settle("raw");
        check({eq_bypass_o, cdr_bypass_o}, 32'h3);
        fn_code <= 8'h00;
        settle("eq only");
        check({eq_bypass_o, cdr_bypass_o}, 32'h1);
        fn_code <= 8'h55;
        settle("clock out");
        check({sclk, eq_bypass_o, cdr_bypass_o}, 32'h4);
        fn_code <= 8'haa;
        xfer(1'b1, rc_pkg::ADDR_CTRL, 32'h60);
        settle("bypass");
        check({eq_bypass_o, cdr_bypass_o}, 32'h2);
        xfer(1'b1, rc_pkg::ADDR_CTRL, 32'h0);
        for (int r = 0; r < 6; r++)
        begin
            rate_sel <= 3'(r);
            settle("rate");
            check({subrate_enable_o, cdr_bypass_o}, (r < 4) ? 32'h2 : (r == 4) ? 32'h0 : 32'h1);
        end
        rate_sel <= 3'h4;
        xfer(1'b1, rc_pkg::ADDR_BOOST, 32'h2a33);
        xfer(1'b1, rc_pkg::ADDR_CTRL, 32'h200);
        settle("slow");
        check({busy, eq_boost_o}, 32'h2a);
        rate_sel <= 3'h2;
        xfer(1'b1, rc_pkg::ADDR_CTRL, 32'h280);
        settle("manual");
        check({busy, eq_boost_o}, 32'h133);
        rate_sel <= 3'h4;
        xfer(1'b1, rc_pkg::ADDR_CTRL, 32'h0);
        settle("abort");
        check(busy, 32'h0);
        rate_sel <= 3'h0;
        carrier_on <= 1'b0;
        settle("restart");
        carrier_on <= 1'b1;
        repeat (4300) @(posedge clk_i);
        check(eq_boost_o, 32'h50);
        xfer(1'b0, rc_pkg::ADDR_STATUS, 32'h0);
        check(rdata[10:6], 32'h15);
        settle("adapt");
        xfer(1'b1, rc_pkg::ADDR_EOM_CFG, 32'h00200001);
        xfer(1'b1, rc_pkg::ADDR_CTRL, 32'h200);
        repeat (8300) @(posedge clk_i);
        check({busy, span}, 32'h20);
        xfer(1'b0, rc_pkg::ADDR_STATUS, 32'h0);
        check(rdata[12:11], 32'h2);
        xfer(1'b0, rc_pkg::ADDR_EYE, 32'h0);
        check({rdata[13:8], rdata[6:0]}, 32'h20);
        xfer(1'b1, rc_pkg::ADDR_HIT_ADDR, 32'h0);
        xfer(1'b0, rc_pkg::ADDR_HIT_DATA, 32'h0);
        h0 = rdata;
        xfer(1'b1, rc_pkg::ADDR_HIT_ADDR, 32'h1);
        xfer(1'b0, rc_pkg::ADDR_HIT_DATA, 32'h0);
        check(h0 + rdata, 32'h1);
        settle("eye");
        give_verdict();
    end
endmodule
